/* File: tb/iso_rx_context_control_tb_top.sv */
// Purpose: Self-checking bench for the receive context control block.
// Assumes: One wait state per register access, as handed over.
// Notes: Status fields are masked where their timing is left open.
`include "iso_rx_ctx_consts.svh"
`default_nettype none
module iso_rx_context_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK, RST, SOFT_RESET, READ, WRITE, WAITREQUEST;
    logic PKT_VALID, PKT_DONE, CYCLE_START, TRAILER_VALID;
    logic [11:0] ADDRESS;
    logic [31:0] WRITEDATA, READDATA, TRAILER, q;
    logic [3:0] BYTEENABLE, DESC_FETCH, FATAL_ERROR, DMA_BUSY, CTX_GO;
    logic [3:0] CTX_WAKE, CTX_PACK, CTX_KEEP_HDR, CTX_ACCEPT;
    logic [12:0] CYCLE_NUMBER, mval;
    logic [15:0] CYCLE_STAMP, st;
    logic [51:0] MATCH_CYCLE;
    logic [23:0] MATCH_CHANNEL;
    logic [63:0] CHANNEL_MASK;
    logic [5:0] PKT_CHANNEL;
    logic [1:0] PKT_CTX;
    logic [2:0] PKT_SPEED;
    logic [4:0] PKT_EVENT;
    logic [31:0] pat [4] = '{32'h8000_0000, 32'h4000_0000,
        32'hC000_0000, 32'h9000_0000};
    int err_count = 0;
    int checks_done = 0;

    iso_rx_context_control #(.N_CTX(4)) dut (.CLK, .RST, .SOFT_RESET,
        .ADDRESS, .READ, .WRITE, .WRITEDATA, .BYTEENABLE, .READDATA,
        .WAITREQUEST, .CYCLE_START, .CYCLE_NUMBER, .CYCLE_STAMP,
        .MATCH_CYCLE, .MATCH_CHANNEL, .CHANNEL_MASK, .PKT_VALID,
        .PKT_CHANNEL, .PKT_DONE, .PKT_CTX, .PKT_SPEED, .PKT_EVENT,
        .DESC_FETCH, .FATAL_ERROR, .DMA_BUSY, .CTX_GO, .CTX_WAKE,
        .CTX_PACK, .CTX_KEEP_HDR, .CTX_ACCEPT, .TRAILER, .TRAILER_VALID);
    iso_rx_far_side far (.clk(CLK), .rst(RST), .go(CTX_GO),
        .cyc_start(CYCLE_START), .cyc_num(CYCLE_NUMBER),
        .stamp(CYCLE_STAMP), .busy(DMA_BUSY));

    initial
    begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    function automatic logic [11:0] sa(input int n);
        return `IRC_SET_OFS + 12'(n * 32);
    endfunction : sa

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // The request is held until waitrequest is seen low at a rising edge.
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge CLK);
        ADDRESS <= a;
        WRITEDATA <= d;
        BYTEENABLE <= be;
        WRITE <= w;
        READ <= !w;
        @(posedge CLK);
        while (WAITREQUEST !== 1'b0)
            @(posedge CLK);
        q = READDATA;
        WRITE <= 1'b0;
        READ <= 1'b0;
    endtask : acc

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0000_0000, 4'hF);
        chk(q, e);
    endtask : rd

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (5000) @(posedge CLK);
        err_count++;
        end_sim();
    end

    initial
    begin
        RST = 1'b1;
        SOFT_RESET = 1'b0;
        READ = 1'b0;
        WRITE = 1'b0;
        ADDRESS = 12'h000;
        WRITEDATA = 32'h0000_0000;
        BYTEENABLE = 4'hF;
        {PKT_VALID, PKT_DONE, PKT_CHANNEL, PKT_CTX} = '0;
        {PKT_SPEED, PKT_EVENT, DESC_FETCH, FATAL_ERROR} = '0;
        MATCH_CYCLE = '0;
        MATCH_CHANNEL = 24'h00_0007;
        CHANNEL_MASK = 64'h0000_0000_0000_0200;
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        for (int n = 0; n < 4; n++)
        begin
            rd(sa(n), 32'h0000_0000);
            wr(sa(n), pat[n] | 32'h0FFF_0000);
            rd(sa(n) + 12'h004, pat[n]);
        end
        acc(1'b1, sa(1), 32'hF000_0000, 4'h7);
        rd(sa(1), pat[1]);
        wr(12'h408, 32'hFFFF_FFFF);
        rd(12'h408, 32'h0000_0000);
        chk({24'h0, CTX_KEEP_HDR, CTX_PACK}, 32'h0000_006D);
        for (int n = 0; n < 4; n++)
        begin
            wr(sa(n) + 12'h004, 32'hFFFF_FFFF);
            rd(sa(n), 32'h0000_0000);
        end
        $display("test map done");
        wr(sa(0), 32'h4000_8000);
        wr(sa(2), 32'h9000_8000);
        rd(sa(0), 32'h4000_8400);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge CLK);
            PKT_VALID <= 1'b1;
            PKT_CHANNEL <= 6'(i == 0 ? 7 : i == 1 ? 9 : 3);
            @(posedge CLK);
            PKT_VALID <= 1'b0;
            @(posedge CLK);
            chk({28'h0, CTX_ACCEPT}, i == 0 ? 1 : i == 1 ? 4 : 0);
        end
        for (int s = 0; s < 4; s++)
        begin
            @(posedge CLK);
            PKT_DONE <= 1'b1;
            PKT_CTX <= (s == 3) ? 2'h2 : 2'h0;
            PKT_SPEED <= 3'(s % 3);
            PKT_EVENT <= 5'h11;
            @(posedge CLK);
            PKT_DONE <= 1'b0;
            st = CYCLE_STAMP;
            @(posedge CLK);
            chk({31'h0, TRAILER_VALID}, (s < 3) ? 1 : 0);
            if (s < 3)
                chk(TRAILER, {16'h8400 | {8'h00, 3'(s % 3), 5'h11}, st});
            acc(1'b0, sa(s == 3 ? 2 : 0), 32'h0000_0000, 4'hF);
            chk(q, ((s < 3) ? 32'h4000_8400 : 32'h9000_8400)
                | {24'h0, 3'(s % 3), 5'h11});
        end
        $display("test packets done");
        wr(sa(0), 32'h0000_1000);
        wr(sa(0) + 12'h004, 32'h0000_1000);
        chk({28'h0, CTX_WAKE}, 32'h0000_0001);
        @(posedge CLK);
        DESC_FETCH <= 4'h1;
        @(posedge CLK);
        DESC_FETCH <= 4'h0;
        @(posedge CLK);
        chk({28'h0, CTX_WAKE}, 32'h0000_0000);
        @(posedge CLK);
        FATAL_ERROR <= 4'h1;
        @(posedge CLK);
        FATAL_ERROR <= 4'h0;
        @(posedge CLK);
        chk({28'h0, CTX_GO}, 32'h0000_0004);
        acc(1'b0, sa(0), 32'h0000_0000, 4'hF);
        chk(q & 32'hFFFF_F800, 32'h4000_8800);
        wr(sa(0) + 12'h004, 32'h0000_8000);
        acc(1'b0, sa(0), 32'h0000_0000, 4'hF);
        chk(q & 32'hFFFF_F800, 32'h4000_0000);
        @(posedge CLK);
        SOFT_RESET <= 1'b1;
        @(posedge CLK);
        SOFT_RESET <= 1'b0;
        acc(1'b0, sa(2), 32'h0000_0000, 4'hF);
        chk(q & 32'hFFFF_F000, 32'h9000_0000);
        $display("test fault and reset done");
        mval = CYCLE_NUMBER + 13'h0003;
        MATCH_CYCLE[51:39] <= mval;
        wr(sa(3), 32'h2000_8000);
        for (int n = 0; n < 200 && CTX_GO[3] !== 1'b1; n++)
            @(posedge CLK);
        chk({19'h0, CYCLE_NUMBER}, {19'h0, mval});
        repeat (4) @(posedge CLK);
        rd(sa(3), 32'h0000_8400);
        $display("test cycle match done");
        end_sim();
    end
endmodule : iso_rx_context_control_tb_top
`default_nettype wire

/* File: tb/iso_rx_far_side.sv */
// Purpose: Far side model: bus cycle starts and the DMA engine.
// Assumes: One clock; a cycle start every 16 clocks.
// Notes: Busy trails go by a cycle, as a real engine's would.
`default_nettype none
module iso_rx_far_side
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] go,
    output logic cyc_start,
    output logic [12:0] cyc_num,
    output logic [15:0] stamp,
    output logic [3:0] busy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] tick;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tick <= 4'h0;
            cyc_start <= 1'b0;
            cyc_num <= 13'h0000;
            stamp <= 16'h0000;
            busy <= 4'h0;
        end
        else
        begin
            tick <= tick + 4'h1;
            cyc_start <= (tick == 4'hF);
            if (tick == 4'hF)
                cyc_num <= cyc_num + 13'h0001;
            stamp <= {3'h0, cyc_num};
            busy <= go;
        end
    end
endmodule : iso_rx_far_side
`default_nettype wire

/* File: verilog/iso_rx_context_control.sv */
// Purpose: Control and status words of the isochronous receive contexts.
// Assumes: All receiver and DMA inputs are on CLK; Avalon-MM slave.
// Notes:
`include "iso_rx_ctx_consts.svh"
`default_nettype none
module iso_rx_context_control
    import iso_rx_ctx_pkg::*;
#(
    parameter int N_CTX = 4
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic SOFT_RESET,
    input wire logic [11:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    input wire logic CYCLE_START,
    input wire logic [12:0] CYCLE_NUMBER,
    input wire logic [15:0] CYCLE_STAMP,
    input wire logic [N_CTX*13-1:0] MATCH_CYCLE,
    input wire logic [N_CTX*6-1:0] MATCH_CHANNEL,
    input wire logic [63:0] CHANNEL_MASK,
    input wire logic PKT_VALID,
    input wire logic [5:0] PKT_CHANNEL,
    input wire logic PKT_DONE,
    input wire logic [1:0] PKT_CTX,
    input wire logic [2:0] PKT_SPEED,
    input wire logic [4:0] PKT_EVENT,
    input wire logic [N_CTX-1:0] DESC_FETCH,
    input wire logic [N_CTX-1:0] FATAL_ERROR,
    input wire logic [N_CTX-1:0] DMA_BUSY,
    output logic [N_CTX-1:0] CTX_GO,
    output logic [N_CTX-1:0] CTX_WAKE,
    output logic [N_CTX-1:0] CTX_PACK,
    output logic [N_CTX-1:0] CTX_KEEP_HDR,
    output logic [N_CTX-1:0] CTX_ACCEPT,
    output logic [31:0] TRAILER,
    output logic TRAILER_VALID
);

    bus_state_t bus_state;
    reg_sel_t sel;
    logic [31:0] wdata;
    logic acc_wr;
    logic [N_CTX-1:0] pack, keep, cmatch, multi, run, wake, dead, active;
    logic [N_CTX-1:0] started, accept;
    logic [2:0] spd [N_CTX];
    logic [4:0] evt [N_CTX];
    logic [31:0] set_bits [N_CTX];
    logic [31:0] clr_bits [N_CTX];

    // Offsets 0 and 4 of each 32-byte slot; anything else is unmapped.
    function automatic reg_sel_t decode_addr(input logic [11:0] a);
        reg_sel_t s;
        logic [11:0] off;
        s = '0;
        off = a - `IRC_SET_OFS;
        if (a >= `IRC_SET_OFS && a < `IRC_WIN_END && off[6:5] < N_CTX)
        begin
            s.ctx = off[6:5];
            if (off[4:0] == 5'h00)
            begin
                s.hit = 1'b1;
            end
            else if (off[4:0] == 5'(`IRC_CLR_OFS - `IRC_SET_OFS))
            begin
                s.hit = 1'b1;
                s.clr = 1'b1;
            end
        end
        return s;
    endfunction : decode_addr

    // Both addresses return the same word; reserved bits stay zero.
    function automatic logic [31:0] ctrl_word(input logic [1:0] c);
        logic [31:0] w;
        w = `IRC_CTRL_RESET;
        w[`IRC_B_PACK] = pack[c];
        w[`IRC_B_KEEP] = keep[c];
        w[`IRC_B_CMATCH] = cmatch[c];
        w[`IRC_B_MULTI] = multi[c];
        w[`IRC_B_RUN] = run[c];
        w[`IRC_B_WAKE] = wake[c];
        w[`IRC_B_DEAD] = dead[c];
        w[`IRC_B_ACTIVE] = active[c];
        w[`IRC_SPD_HI:`IRC_SPD_LO] = spd[c];
        w[`IRC_EVT_HI:0] = evt[c];
        return w;
    endfunction : ctrl_word

    // One wait cycle per access gives the read mux a registered path.
    always_ff @(posedge CLK)
    begin
        if (RST)
            bus_state <= BUS_IDLE;
        else
        begin
            case (bus_state)
                BUS_IDLE:
                    if (READ || WRITE)
                        bus_state <= BUS_ACK;
                BUS_ACK:
                    bus_state <= BUS_IDLE;
                default:
                    bus_state <= BUS_IDLE;
            endcase
        end
    end

    assign WAITREQUEST = (READ || WRITE) && bus_state == BUS_IDLE;
    assign sel = decode_addr(ADDRESS);
    assign acc_wr = WRITE && bus_state == BUS_ACK && sel.hit;
    assign wdata = WRITEDATA & {{8{BYTEENABLE[3]}}, {8{BYTEENABLE[2]}},
        {8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};

    always_ff @(posedge CLK)
    begin
        if (RST)
            READDATA <= 32'h0000_0000;
        else if (READ && bus_state == BUS_IDLE)
            READDATA <= sel.hit ? ctrl_word(sel.ctx) : 32'h0000_0000;
    end

    genvar c;
    generate
        for (c = 0; c < N_CTX; c++)
        begin : g_ctx
            logic cyc_hit;
            logic chan_ok;
            // Clear writes to the wake bit are ignored: it is set-only.
            assign set_bits[c] = (acc_wr && !sel.clr && sel.ctx == c) ?
                (wdata & `IRC_SET_MASK) : 32'h0000_0000;
            assign clr_bits[c] = (acc_wr && sel.clr && sel.ctx == c) ?
                (wdata & `IRC_CLR_MASK) : 32'h0000_0000;
            assign cyc_hit = CYCLE_START &&
                CYCLE_NUMBER == MATCH_CYCLE[c*13 +: 13];
            // Multi-channel ignores the match channel entirely.
            assign chan_ok = multi[c] ? CHANNEL_MASK[PKT_CHANNEL] :
                PKT_CHANNEL == MATCH_CHANNEL[c*6 +: 6];

            always_ff @(posedge CLK)
            begin
                if (RST || SOFT_RESET)
                    run[c] <= 1'b0;
                else if (set_bits[c][`IRC_B_RUN])
                    run[c] <= 1'b1;
                else if (clr_bits[c][`IRC_B_RUN])
                    run[c] <= 1'b0;
            end

            always_ff @(posedge CLK)
            begin
                if (RST)
                begin
                    pack[c] <= 1'b0;
                    keep[c] <= 1'b0;
                    multi[c] <= 1'b0;
                end
                else
                begin
                    if (set_bits[c][`IRC_B_PACK])
                        pack[c] <= 1'b1;
                    else if (clr_bits[c][`IRC_B_PACK])
                        pack[c] <= 1'b0;
                    if (set_bits[c][`IRC_B_KEEP])
                        keep[c] <= 1'b1;
                    else if (clr_bits[c][`IRC_B_KEEP])
                        keep[c] <= 1'b0;
                    if (set_bits[c][`IRC_B_MULTI])
                        multi[c] <= 1'b1;
                    else if (clr_bits[c][`IRC_B_MULTI])
                        multi[c] <= 1'b0;
                end
            end

            // A software set in the same cycle beats the hardware clear.
            always_ff @(posedge CLK)
            begin
                if (RST)
                    cmatch[c] <= 1'b0;
                else if (set_bits[c][`IRC_B_CMATCH])
                    cmatch[c] <= 1'b1;
                else if (clr_bits[c][`IRC_B_CMATCH] || active[c])
                    cmatch[c] <= 1'b0;
            end

            always_ff @(posedge CLK)
            begin
                if (RST)
                    started[c] <= 1'b0;
                else if (!run[c])
                    started[c] <= 1'b0;
                else if (!cmatch[c] || cyc_hit)
                    started[c] <= 1'b1;
            end

            always_ff @(posedge CLK)
            begin
                if (RST)
                    wake[c] <= 1'b0;
                else if (set_bits[c][`IRC_B_WAKE])
                    wake[c] <= 1'b1;
                else if (DESC_FETCH[c])
                    wake[c] <= 1'b0;
            end

            always_ff @(posedge CLK)
            begin
                if (RST)
                    dead[c] <= 1'b0;
                else if (FATAL_ERROR[c])
                    dead[c] <= 1'b1;
                else if (clr_bits[c][`IRC_B_RUN])
                    dead[c] <= 1'b0;
            end

            always_ff @(posedge CLK)
            begin
                if (RST)
                    active[c] <= 1'b0;
                else
                    active[c] <= DMA_BUSY[c];
            end

            always_ff @(posedge CLK)
            begin
                if (RST)
                begin
                    spd[c] <= `IRC_SPD_100;
                    evt[c] <= 5'h00;
                end
                else if (PKT_DONE && PKT_CTX == c)
                begin
                    spd[c] <= PKT_SPEED;
                    evt[c] <= PKT_EVENT;
                end
            end

            always_ff @(posedge CLK)
            begin
                if (RST)
                    accept[c] <= 1'b0;
                else
                    accept[c] <= PKT_VALID && CTX_GO[c] && chan_ok;
            end

            assign CTX_GO[c] = run[c] && started[c] && !dead[c];
        end
    endgenerate

    assign CTX_WAKE = wake;
    assign CTX_PACK = pack;
    // The writer puts the header words first, then payload.
    assign CTX_KEEP_HDR = keep;
    assign CTX_ACCEPT = accept;

    // Status doublet first, then the stamp of the latest cycle start.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            TRAILER <= 32'h0000_0000;
            TRAILER_VALID <= 1'b0;
        end
        else
        begin
            TRAILER_VALID <= PKT_DONE && keep[PKT_CTX];
            if (PKT_DONE && keep[PKT_CTX])
                TRAILER <= {run[PKT_CTX], 2'b00, wake[PKT_CTX],
                    dead[PKT_CTX], active[PKT_CTX], 2'b00, PKT_SPEED,
                    PKT_EVENT, CYCLE_STAMP};
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_run_set;
        WRITE && bus_state == BUS_ACK && ADDRESS == `IRC_SET_OFS
            && WRITEDATA[`IRC_B_RUN] && BYTEENABLE[1] && !SOFT_RESET
            |=> run[0];
    endproperty
    a_run_set: assert property (p_run_set)
        else $error("Run not set by set write.");

    property p_run_only_sw;
        $rose(run[0]) |-> $past(set_bits[0][`IRC_B_RUN]);
    endproperty
    a_run_only_sw: assert property (p_run_only_sw)
        else $error("Run rose without a set write.");

    property p_run_softreset;
        SOFT_RESET |=> !run[0] && !CTX_GO[0];
    endproperty
    a_run_softreset: assert property (p_run_softreset)
        else $error("Run survived software reset.");

    property p_rsvd_zero;
        READ && !WAITREQUEST |-> READDATA[27:16] == 12'h000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("Reserved bits read nonzero.");

    property p_wake_fetch;
        DESC_FETCH[0] && !set_bits[0][`IRC_B_WAKE] |=> !CTX_WAKE[0];
    endproperty
    a_wake_fetch: assert property (p_wake_fetch)
        else $error("Wake not cleared on fetch.");

    property p_dead_stays;
        FATAL_ERROR[0] |=> dead[0] && !CTX_GO[0];
    endproperty
    a_dead_stays: assert property (p_dead_stays)
        else $error("Fatal error did not halt context.");

    property p_cm_clear;
        DMA_BUSY[N_CTX-1] ##1 !set_bits[N_CTX-1][`IRC_B_CMATCH]
            |=> !cmatch[N_CTX-1];
    endproperty
    a_cm_clear: assert property (p_cm_clear)
        else $error("Cycle match bit not cleared when active.");

    property p_cm_wait;
        $rose(started[N_CTX-1]) && $past(cmatch[N_CTX-1]) |->
            $past(CYCLE_START &&
                CYCLE_NUMBER == MATCH_CYCLE[(N_CTX-1)*13 +: 13]);
    endproperty
    a_cm_wait: assert property (p_cm_wait)
        else $error("Context started without cycle match.");

    property p_multi_mask;
        PKT_VALID && multi[N_CTX/2] && !CHANNEL_MASK[PKT_CHANNEL]
            |=> !CTX_ACCEPT[N_CTX/2];
    endproperty
    a_multi_mask: assert property (p_multi_mask)
        else $error("Masked channel accepted.");

    property p_single_chan;
        PKT_VALID && !multi[0] && PKT_CHANNEL != MATCH_CHANNEL[5:0]
            |=> !CTX_ACCEPT[0];
    endproperty
    a_single_chan: assert property (p_single_chan)
        else $error("Foreign channel accepted.");

    property p_active;
        DMA_BUSY[0] |=> active[0];
    endproperty
    a_active: assert property (p_active)
        else $error("Active flag low while busy.");

endmodule : iso_rx_context_control
`default_nettype wire

/* File: verilog/iso_rx_ctx_consts.svh */
// Purpose: Offsets, field positions, masks and reset values.
// Assumes: Byte addresses on the register bus.
// Notes: Definitions only.
`ifndef ISO_RX_CTX_CONSTS_SVH
`define ISO_RX_CTX_CONSTS_SVH
`define IRC_SET_OFS 12'h400
`define IRC_CLR_OFS 12'h404
`define IRC_STRIDE 12'h020
`define IRC_WIN_END 12'h480
`define IRC_B_PACK 31
`define IRC_B_KEEP 30
`define IRC_B_CMATCH 29
`define IRC_B_MULTI 28
`define IRC_B_RUN 15
`define IRC_B_WAKE 12
`define IRC_B_DEAD 11
`define IRC_B_ACTIVE 10
`define IRC_SPD_HI 7
`define IRC_SPD_LO 5
`define IRC_EVT_HI 4
`define IRC_SET_MASK 32'hF000_9000
`define IRC_CLR_MASK 32'hF000_8000
`define IRC_SPD_100 3'h0
`define IRC_SPD_200 3'h1
`define IRC_SPD_400 3'h2
`define IRC_CTRL_RESET 32'h0000_0000
`endif

/* File: verilog/iso_rx_ctx_pkg.sv */
// Purpose: Types shared by the receive context control block.
// Assumes: Constants come from iso_rx_ctx_consts.svh.
// Notes: None.
`default_nettype none
package iso_rx_ctx_pkg;
    typedef struct packed {
        logic hit;
        logic clr;
        logic [1:0] ctx;
    } reg_sel_t;
    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;
endpackage : iso_rx_ctx_pkg
`default_nettype wire
